// >>> pvc_checker.sv
// privilege and virtual-8086 mode checker with AHB-Lite register slave
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module pvc_checker #(
    parameter int ADDR_W = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             prot_fault_q,
    output logic             v86_active_q
);
    // bus address phase capture
    logic              wr_pend_q, wr_pend_d;
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic              rd_pend_d;
    logic [ADDR_W-1:0] rd_addr_d;
    logic [31:0]       hrdata_d;

    // software-visible state
    logic [31:0] ctrl_q, ctrl_d;          // control word zero
    logic [31:0] flags_q, flags_d;        // flags word
    logic [31:0] req_q, req_d;            // request: op, xfer kind, priv, tss size
    logic [31:0] desc_q, desc_d;          // descriptor under check
    logic [31:0] segoff_q, segoff_d;      // segment[31:16] offset[15:0]
    logic [31:0] linear_q, linear_d;
    logic [31:0] stack_q, stack_d;        // new stack level / old level pushed
    logic [1:0]  cpl_q, cpl_d;
    logic [1:0]  mode_q, mode_d;
    pvc_pkg::pvc_result_s res_q, res_d;
    logic [15:0] seg_limit_q, seg_limit_d;
    logic        fault_d, v86_d;
    logic        go;
    logic        eval_q;

    pvc_pkg::pvc_desc_s dsc;
    logic [3:0]  op;
    logic [2:0]  xk;
    logic [1:0]  requested_priv_level, io_privilege_field, effective_priv_level;
    logic        tss32, is_v86, is_prot, ioz, sens, is_event;
    logic        type_ok, gate_ok, deeper, image_vm;

    function automatic logic [1:0] less_priv(input logic [1:0] a, input logic [1:0] b);
        less_priv = (a > b) ? a : b;
    endfunction

    function automatic logic in_gl(input logic [1:0] t);
        in_gl = (t == 2'(pvc_pkg::PVC_TB_GLOBAL)) || (t == 2'(pvc_pkg::PVC_TB_LOCAL));
    endfunction

    assign go = wr_pend_q && (wr_addr_q == ADDR_W'(pvc_pkg::REG_REQ));

    // request decode
    always_comb begin
        dsc      = pvc_pkg::pvc_desc_s'(desc_q[11:0]);
        op       = req_q[3:0];
        xk       = req_q[6:4];
        requested_priv_level      = req_q[9:8];
        tss32    = req_q[12];
        image_vm = req_q[13];              // vm bit of stacked or task-block flags image
        is_event = req_q[14];              // transfer caused by interrupt or exception
        io_privilege_field     = flags_q[pvc_pkg::FL_IO_PRIVILEGE_FIELD +: 2];
        is_v86   = (mode_q == 2'(pvc_pkg::PVC_MD_V86));
        is_prot  = (mode_q == 2'(pvc_pkg::PVC_MD_PROT));
        effective_priv_level      = less_priv(requested_priv_level, cpl_q);
        ioz      = (cpl_q <= io_privilege_field);
        // which operations test the io field differs by mode
        if (is_v86) begin
            sens = (op == 4'(pvc_pkg::PVC_OP_CLI)) || (op == 4'(pvc_pkg::PVC_OP_STI))
                || (op == 4'(pvc_pkg::PVC_OP_INTN)) || (op == 4'(pvc_pkg::PVC_OP_FLAGS_POP))
                || (op == 4'(pvc_pkg::PVC_OP_FLAGS_PUSH))
                || (op == 4'(pvc_pkg::PVC_OP_XFER) && xk == 3'(pvc_pkg::PVC_XF_INTERRUPT_RETURN));
        end else begin
            sens = (op == 4'(pvc_pkg::PVC_OP_CLI)) || (op == 4'(pvc_pkg::PVC_OP_STI))
                || (op == 4'(pvc_pkg::PVC_OP_IO))
                || (op == 4'(pvc_pkg::PVC_OP_FLAGS_POP) && req_q[15]); // pop touching interrupt flag
        end
        gate_ok = (effective_priv_level <= dsc.descriptor_priv_level);
        deeper  = (dsc.target_dpl < cpl_q);
        // descriptor type check per transfer kind
        type_ok = 1'b0;
        if (is_event) begin
            type_ok = (dsc.table_sel == 2'(pvc_pkg::PVC_TB_INTR))
                && (dsc.dtype == 3'(pvc_pkg::PVC_DT_TRAP_GATE) || dsc.dtype == 3'(pvc_pkg::PVC_DT_INT_GATE)
                    || dsc.dtype == 3'(pvc_pkg::PVC_DT_TASK_GATE));
        end else begin
            unique case (xk)
                3'(pvc_pkg::PVC_XF_JMP), 3'(pvc_pkg::PVC_XF_CALL): begin
                    type_ok = (in_gl(dsc.table_sel) && dsc.dtype == 3'(pvc_pkg::PVC_DT_CODE))
                        || (in_gl(dsc.table_sel) && dsc.dtype == 3'(pvc_pkg::PVC_DT_TASK_GATE))
                        || (dsc.table_sel == 2'(pvc_pkg::PVC_TB_GLOBAL) && dsc.dtype == 3'(pvc_pkg::PVC_DT_TSS))
                        || (xk == 3'(pvc_pkg::PVC_XF_CALL) && in_gl(dsc.table_sel)
                            && dsc.dtype == 3'(pvc_pkg::PVC_DT_CALL_GATE));
                end
                3'(pvc_pkg::PVC_XF_INTERRUPT_RETURN): begin
                    if (flags_q[pvc_pkg::FL_NT])
                        type_ok = dsc.table_sel == 2'(pvc_pkg::PVC_TB_INTR)
                            && dsc.dtype == 3'(pvc_pkg::PVC_DT_TASK_GATE);
                    else
                        type_ok = in_gl(dsc.table_sel) && dsc.dtype == 3'(pvc_pkg::PVC_DT_CODE);
                end
                default: type_ok = in_gl(dsc.table_sel) && dsc.dtype == 3'(pvc_pkg::PVC_DT_CODE);
            endcase
        end
    end

    // checker state
    always_comb begin
        logic [31:0] lin;
        lin         = 32'h0;
        mode_d      = mode_q;
        cpl_d       = cpl_q;
        flags_d     = flags_q;
        res_d       = res_q;
        linear_d    = linear_q;
        stack_d     = stack_q;
        seg_limit_d = seg_limit_q;
        if (wr_pend_q && wr_addr_q == ADDR_W'(pvc_pkg::REG_FLAGS)) begin
            flags_d = hwdata;
            flags_d[pvc_pkg::FL_VM] = flags_q[pvc_pkg::FL_VM]; // vm only moves by transfers
        end
        // protect bit: real <-> protected; paging bit is left alone in any mode
        if (wr_pend_q && wr_addr_q == ADDR_W'(pvc_pkg::REG_CTRL) && !is_v86) begin
            mode_d = hwdata[pvc_pkg::CTL_PE] ? 2'(pvc_pkg::PVC_MD_PROT) : 2'(pvc_pkg::PVC_MD_REAL);
            if (!hwdata[pvc_pkg::CTL_PE])
                cpl_d = pvc_pkg::PRIV_MOST;
        end
        if (go) begin
            res_d = '0;
            res_d.eff_priv = less_priv(hwdata[9:8], cpl_q);
        end else if (wr_pend_q && wr_addr_q == ADDR_W'(pvc_pkg::REG_RESULT)) begin
            res_d = '0;
        end
        // evaluation one cycle after the request write
        if (eval_q) begin
            res_d.eff_priv = effective_priv_level;
            if (sens && !ioz && (is_prot || is_v86)) begin
                if (!tss32 || is_v86 || op != 4'(pvc_pkg::PVC_OP_IO))
                    res_d.verdict = 2'(pvc_pkg::PVC_VR_GP);
                else
                    res_d.verdict = 2'(pvc_pkg::PVC_VR_BITMAP);
            end else if (is_v86 && op == 4'(pvc_pkg::PVC_OP_PRIV)) begin
                res_d.verdict = 2'(pvc_pkg::PVC_VR_GP);
            end else if (op == 4'(pvc_pkg::PVC_OP_FLAGS_POP)) begin
                flags_d = {flags_q[31:18], flags_q[pvc_pkg::FL_VM], segoff_q[16:0]};
                if (cpl_q != pvc_pkg::PRIV_MOST && is_prot)
                    flags_d[pvc_pkg::FL_IO_PRIVILEGE_FIELD +: 2] = io_privilege_field;
                res_d.verdict = 2'(pvc_pkg::PVC_VR_OK);
            end else if (op == 4'(pvc_pkg::PVC_OP_ADDR)) begin
                if (is_v86) begin
                    lin = ({16'h0, segoff_q[31:16]} << pvc_pkg::SEG_SHIFT) + {16'h0, segoff_q[15:0]};
                    linear_d = lin;
                    if (lin >= pvc_pkg::V86_SPACE_TOP)
                        res_d.verdict = 2'(pvc_pkg::PVC_VR_LIMIT);
                end else if (mode_q == 2'(pvc_pkg::PVC_MD_REAL)) begin
                    linear_d = ({16'h0, segoff_q[31:16]} << pvc_pkg::SEG_SHIFT) + {16'h0, segoff_q[15:0]};
                end
            end else if (op == 4'(pvc_pkg::PVC_OP_EVENT) && is_v86) begin
                // only a 32-bit gate to nonconforming level-0 code, or a 32-bit task gate
                if (dsc.is_big && ((!dsc.conforming && dsc.target_dpl == pvc_pkg::PRIV_MOST
                        && (dsc.dtype == 3'(pvc_pkg::PVC_DT_TRAP_GATE)
                            || dsc.dtype == 3'(pvc_pkg::PVC_DT_INT_GATE)))
                        || dsc.dtype == 3'(pvc_pkg::PVC_DT_TASK_GATE))) begin
                    mode_d = 2'(pvc_pkg::PVC_MD_PROT);
                    cpl_d  = pvc_pkg::PRIV_MOST;
                    stack_d = {30'h0, pvc_pkg::PRIV_MOST} | {flags_q[pvc_pkg::FL_VM], 31'h0}; // image keeps vm
                    flags_d[pvc_pkg::FL_VM] = 1'b0;
                    res_d.changed_priv = 1'b1;
                end else begin
                    res_d.verdict = 2'(pvc_pkg::PVC_VR_GP);
                end
            end else if (op == 4'(pvc_pkg::PVC_OP_XFER) || op == 4'(pvc_pkg::PVC_OP_INTN)) begin
                if (!type_ok || (dsc.dtype != 3'(pvc_pkg::PVC_DT_CODE) && !is_event && !gate_ok)) begin
                    res_d.verdict = 2'(pvc_pkg::PVC_VR_GP);
                end else if (dsc.dtype == 3'(pvc_pkg::PVC_DT_CODE) && !is_event && !dsc.conforming
                        && (xk == 3'(pvc_pkg::PVC_XF_JMP) || xk == 3'(pvc_pkg::PVC_XF_CALL))
                        && dsc.target_dpl != cpl_q) begin
                    // a direct jump or call may not change level; that needs a gate
                    res_d.verdict = 2'(pvc_pkg::PVC_VR_GP);
                end else if (is_prot && xk == 3'(pvc_pkg::PVC_XF_INTERRUPT_RETURN) && image_vm
                        && cpl_q == pvc_pkg::PRIV_MOST) begin
                    mode_d = 2'(pvc_pkg::PVC_MD_V86);
                    cpl_d  = pvc_pkg::PRIV_LEAST;
                    seg_limit_d = pvc_pkg::SEG_LIMIT_V86;
                    flags_d[pvc_pkg::FL_VM] = 1'b1;
                    res_d.changed_priv = 1'b1;
                end else if (is_prot && dsc.dtype != 3'(pvc_pkg::PVC_DT_CODE) && deeper
                        && dsc.dtype != 3'(pvc_pkg::PVC_DT_TSS) && dsc.dtype != 3'(pvc_pkg::PVC_DT_TASK_GATE)) begin
                    cpl_d   = dsc.target_dpl;
                    stack_d = {cpl_q, 28'h0, dsc.target_dpl};             // old level, new stack slot
                    res_d.changed_priv = 1'b1;
                end else if (is_prot && (dsc.dtype == 3'(pvc_pkg::PVC_DT_TSS)
                        || dsc.dtype == 3'(pvc_pkg::PVC_DT_TASK_GATE))) begin
                    cpl_d = dsc.target_dpl;
                    if (image_vm) begin
                        mode_d = 2'(pvc_pkg::PVC_MD_V86);
                        cpl_d  = pvc_pkg::PRIV_LEAST;
                        seg_limit_d = pvc_pkg::SEG_LIMIT_V86;
                        flags_d[pvc_pkg::FL_VM] = 1'b1;
                    end
                    res_d.changed_priv = (cpl_d != cpl_q);
                end else if (is_prot && (xk == 3'(pvc_pkg::PVC_XF_RET) || xk == 3'(pvc_pkg::PVC_XF_INTERRUPT_RETURN))
                        && dsc.target_dpl > cpl_q) begin
                    cpl_d = dsc.target_dpl;                               // outward return drops level; stack left as is
                    res_d.changed_priv = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            eval_q <= 1'b0;
        else
            eval_q <= go;
    end

    // bus slave: zero-wait writes and reads, always okay
    always_comb begin
        wr_pend_d = hsel && hready && htrans[1] && hwrite;
        wr_addr_d = haddr[ADDR_W-1:0];
        rd_pend_d = hsel && hready && htrans[1] && !hwrite;
        rd_addr_d = haddr[ADDR_W-1:0];
        hrdata_d  = hrdata;
        ctrl_d    = ctrl_q;
        req_d     = req_q;
        desc_d    = desc_q;
        segoff_d  = segoff_q;
        if (wr_pend_q) begin
            unique case (wr_addr_q)
                ADDR_W'(pvc_pkg::REG_CTRL):   ctrl_d   = hwdata;
                ADDR_W'(pvc_pkg::REG_REQ):    req_d    = hwdata;
                ADDR_W'(pvc_pkg::REG_DESC):   desc_d   = hwdata;
                ADDR_W'(pvc_pkg::REG_SEGOFF): segoff_d = hwdata;
                default: ;
            endcase
        end
        if (rd_pend_d) begin
            unique case (rd_addr_d)
                ADDR_W'(pvc_pkg::REG_CTRL):   hrdata_d = ctrl_q;
                ADDR_W'(pvc_pkg::REG_FLAGS):  hrdata_d = flags_q;
                ADDR_W'(pvc_pkg::REG_REQ):    hrdata_d = req_q;
                ADDR_W'(pvc_pkg::REG_DESC):   hrdata_d = desc_q;
                ADDR_W'(pvc_pkg::REG_SEGOFF): hrdata_d = segoff_q;
                ADDR_W'(pvc_pkg::REG_RESULT): hrdata_d = {27'h0, res_q};
                ADDR_W'(pvc_pkg::REG_STATE):  hrdata_d = {10'h0, seg_limit_q, eval_q, 1'b0, cpl_q, mode_q};
                ADDR_W'(pvc_pkg::REG_LINEAR): hrdata_d = linear_q;
                ADDR_W'(pvc_pkg::REG_STACK):  hrdata_d = stack_q;
                default:                      hrdata_d = 32'h0;
            endcase
        end
        fault_d = (res_d.verdict == 2'(pvc_pkg::PVC_VR_GP)) || (res_d.verdict == 2'(pvc_pkg::PVC_VR_LIMIT));
        v86_d   = (mode_d == 2'(pvc_pkg::PVC_MD_V86));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q    <= 1'b0;
            wr_addr_q    <= '0;
            hrdata       <= 32'h0;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            ctrl_q       <= 32'h0;
            flags_q      <= 32'h0000_0002;
            req_q        <= 32'h0;
            desc_q       <= 32'h0;
            segoff_q     <= 32'h0;
            linear_q     <= 32'h0;
            stack_q      <= 32'h0;
            cpl_q        <= pvc_pkg::PRIV_MOST;
            mode_q       <= 2'(pvc_pkg::PVC_MD_REAL);
            res_q        <= '0;
            seg_limit_q  <= pvc_pkg::SEG_LIMIT_V86;
            prot_fault_q <= 1'b0;
            v86_active_q <= 1'b0;
        end else begin
            wr_pend_q    <= wr_pend_d;
            wr_addr_q    <= wr_addr_d;
            hrdata       <= hrdata_d;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            ctrl_q       <= ctrl_d;
            flags_q      <= flags_d;
            req_q        <= req_d;
            desc_q       <= desc_d;
            segoff_q     <= segoff_d;
            linear_q     <= linear_d;
            stack_q      <= stack_d;
            cpl_q        <= cpl_d;
            mode_q       <= mode_d;
            res_q        <= res_d;
            seg_limit_q  <= seg_limit_d;
            prot_fault_q <= fault_d;
            v86_active_q <= v86_d;
        end
    end
endmodule

// >>> pvc_pkg.sv
// package for the privilege and virtual-8086 mode checker
package pvc_pkg;
    localparam logic [1:0]  PRIV_MOST  = 2'h0;
    localparam logic [1:0]  PRIV_LEAST = 2'h3;
    localparam logic [15:0] SEG_LIMIT_V86 = 16'hffff;
    localparam logic [3:0]  SEG_SHIFT  = 4'h4;
    localparam logic [31:0] V86_SPACE_TOP = 32'h0010_0000;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_FLAGS  = 8'h04;
    localparam logic [7:0] REG_REQ    = 8'h08;
    localparam logic [7:0] REG_DESC   = 8'h0c;
    localparam logic [7:0] REG_SEGOFF = 8'h10;
    localparam logic [7:0] REG_RESULT = 8'h14;
    localparam logic [7:0] REG_STATE  = 8'h18;
    localparam logic [7:0] REG_LINEAR = 8'h1c;
    localparam logic [7:0] REG_STACK  = 8'h20;

    // flags and control word field positions
    localparam int FL_IF   = 9;
    localparam int FL_IO_PRIVILEGE_FIELD = 12;
    localparam int FL_NT   = 14;
    localparam int FL_VM   = 17;
    localparam int CTL_PE  = 0;
    localparam int CTL_PG  = 31;

    typedef enum logic [3:0] {
        PVC_OP_NONE, PVC_OP_CLI, PVC_OP_STI, PVC_OP_IO, PVC_OP_FLAGS_POP, PVC_OP_FLAGS_PUSH,
        PVC_OP_INTN, PVC_OP_BREAKPOINT_INTERRUPT, PVC_OP_INTO, PVC_OP_BOUND, PVC_OP_PRIV, PVC_OP_XFER,
        PVC_OP_ADDR, PVC_OP_EVENT
    } pvc_op_e;

    typedef enum logic [2:0] {
        PVC_XF_JMP, PVC_XF_CALL, PVC_XF_RET, PVC_XF_INTERRUPT_RETURN
    } pvc_xfer_e;

    typedef enum logic [2:0] {
        PVC_DT_CODE, PVC_DT_CALL_GATE, PVC_DT_TRAP_GATE, PVC_DT_INT_GATE, PVC_DT_TSS, PVC_DT_TASK_GATE
    } pvc_dtype_e;

    typedef enum logic [1:0] { PVC_TB_GLOBAL, PVC_TB_LOCAL, PVC_TB_INTR } pvc_table_e;

    typedef enum logic [1:0] { PVC_MD_REAL, PVC_MD_PROT, PVC_MD_V86 } pvc_mode_e;

    typedef enum logic [1:0] { PVC_VR_OK, PVC_VR_GP, PVC_VR_BITMAP, PVC_VR_LIMIT } pvc_verdict_e;

    typedef struct packed {
        logic        is_big;     // descriptor/gate is 32-bit
        logic        conforming;
        logic [1:0]  descriptor_priv_level;
        logic [1:0]  table_sel;
        logic [2:0]  dtype;
        logic [1:0]  target_dpl;
    } pvc_desc_s;

    typedef struct packed {
        logic [1:0]  verdict;
        logic        changed_priv;
        logic [1:0]  eff_priv;
    } pvc_result_s;
endpackage

// >>> pvc_checker_monitor.sv
// assertion checker bound to the ports of the privilege and virtual-8086 mode checker
`timescale 1ns/1ps
module pvc_checker_monitor #(
    parameter int ADDR_W = 8
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        prot_fault_q,
    input wire logic        v86_active_q
);
    logic [2:0] req_age_q;
    logic [2:0] req_age_d;
    logic       rd_ph;
    // state may only move in the edges after a request write; reads inside that span could race it
    always_comb begin
        req_age_d = (req_age_q != 3'h0) ? req_age_q - 3'h1 : 3'h0;
        if (hsel && hready && htrans[1] && hwrite && haddr[7:0] == pvc_pkg::REG_REQ) begin
            req_age_d = 3'h3;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_age_q <= 3'h0;
        end else begin
            req_age_q <= req_age_d;
        end
    end
    assign rd_ph = hsel && hready && htrans[1] && !hwrite && req_age_q == 3'h0;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_zero_wait: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
    chk_reset_real_mode: assert property ($rose(hresetn) |-> !v86_active_q)
        else $error("virtual-8086 mode active right after reset");
    chk_v86_entry_cause: assert property ($rose(v86_active_q) |-> req_age_q != 3'h0)
        else $error("virtual-8086 mode entered without a request");
    chk_v86_exit_cause: assert property ($fell(v86_active_q) |-> req_age_q != 3'h0)
        else $error("virtual-8086 mode left without a request");
    chk_fault_cause: assert property ($rose(prot_fault_q) |-> req_age_q != 3'h0)
        else $error("fault raised without a request");
    chk_unmapped_zero: assert property (rd_ph && haddr[7:0] > pvc_pkg::REG_STACK |=> hrdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    chk_v86_state_read: assert property (rd_ph && haddr[7:0] == pvc_pkg::REG_STATE && v86_active_q
        |=> hrdata[3:0] == 4'he && hrdata[21:6] == pvc_pkg::SEG_LIMIT_V86)
        else $error("virtual-8086 state not at level 3 with full limits");
    chk_state_not_v86: assert property (rd_ph && haddr[7:0] == pvc_pkg::REG_STATE && !v86_active_q
        |=> hrdata[1:0] != 2'h2)
        else $error("state shows virtual-8086 while flag is low");
    chk_result_fault: assert property (rd_ph && haddr[7:0] == pvc_pkg::REG_RESULT |=> hrdata[3] == prot_fault_q)
        else $error("fault output disagrees with result verdict");
    cov_v86_entry: cover property ($rose(v86_active_q));
    cov_v86_exit: cover property ($fell(v86_active_q));
    cov_fault: cover property ($rose(prot_fault_q));
endmodule
bind pvc_checker pvc_checker_monitor #(.ADDR_W(ADDR_W)) u_pvc_checker_monitor (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .prot_fault_q(prot_fault_q), .v86_active_q(v86_active_q));

// >>> tb_pvc_checker.sv
// self-checking testbench for the privilege and virtual-8086 mode checker
`timescale 1ns/1ps
module tb_pvc_checker;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, prot_fault_q, v86_active_q;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          err_count, samples_checked;
    pvc_checker #(.ADDR_W(8)) u_pvc_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .prot_fault_q(prot_fault_q), .v86_active_q(v86_active_q));
    assign hready = hreadyout;
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // single word transfer; the wait for hready is bounded so a stuck slave ends in a mismatch
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 40);
        rd = hrdata;
        if (n >= 20) begin
            err_count++;
            $display("BAD t=%0t bus hang", $time);
        end
    endtask
    task automatic req(input logic [31:0] desc, input logic [31:0] so, input logic [31:0] rq);
        bus(1'b1, pvc_pkg::REG_DESC, desc);
        bus(1'b1, pvc_pkg::REG_SEGOFF, so);
        bus(1'b1, pvc_pkg::REG_REQ, rq);
        repeat (2) @(posedge hclk);
        bus(1'b0, pvc_pkg::REG_RESULT, 32'h0);
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic t_reset();
        do_reset();
        bus(1'b0, pvc_pkg::REG_STATE, 32'h0);
        expect_eq(rd & 32'h003f_ffef, 32'h003f_ffc0, "state after reset");
        bus(1'b0, pvc_pkg::REG_FLAGS, 32'h0);
        expect_eq(rd, 32'h0000_0002, "flags after reset");
        bus(1'b0, 8'h40, 32'h0);
        expect_eq(rd, 32'h0, "unmapped read");
        bus(1'b1, pvc_pkg::REG_FLAGS, 32'h0002_0002);
        bus(1'b0, pvc_pkg::REG_FLAGS, 32'h0);
        expect_eq(rd, 32'h0000_0002, "vm bit written through flags");
        $display("test reset done");
    endtask
    task automatic t_prot();
        logic [31:0] io_t [7] = '{32'h0004_0301, 32'h0004_0303, 32'h0008_1303, 32'h0004_1302, 32'h0004_9304,
                                  32'h0003_0301, 32'h0003_1303};
        logic [31:0] xf_t [5] = '{32'h0188_030b, 32'h0004_031b, 32'h01d4_031b, 32'h01c3_032b, 32'h0000_030b};
        bus(1'b1, pvc_pkg::REG_CTRL, 32'h1);
        bus(1'b0, pvc_pkg::REG_STATE, 32'h0);
        expect_eq({28'h0, rd[3:0]}, 32'h1, "protected mode at level 0");
        req(32'h183, 32'h0, 32'h32b);
        expect_eq({27'h0, rd[4:0]}, 32'h7, "outward return result");
        req(32'h183, 32'h0, 32'h233b);
        expect_eq({31'h0, v86_active_q}, 32'h0, "interrupt_return entry at level 3");
        foreach (io_t[i]) begin
            bus(1'b1, pvc_pkg::REG_FLAGS, {18'h0, io_t[i][17:16], 12'h002});
            req(32'h0, 32'h200, {16'h0, io_t[i][15:0]});
            expect_eq({27'h0, rd[4:0]}, {27'h0, io_t[i][19:18], 3'h3}, "io verdict");
            expect_eq({31'h0, prot_fault_q}, {31'h0, io_t[i][18]}, "io fault");
        end
        req(32'h0, 32'h0003_0202, 32'h0000_0304);
        bus(1'b0, pvc_pkg::REG_FLAGS, 32'h0);
        expect_eq(rd, 32'h0001_3202, "flags pop keeps vm and io field");
        foreach (xf_t[i]) begin
            req({20'h0, xf_t[i][27:16]}, 32'h0, {20'h0, xf_t[i][11:0]});
            expect_eq({30'h0, rd[4:3]}, 32'h1, "refused transfer");
            expect_eq({31'h0, prot_fault_q}, 32'h1, "transfer fault");
        end
        $display("test protected done");
    endtask
    task automatic t_v86();
        logic [31:0] so_t [3] = '{32'h1234_0010, 32'hffff_000f, 32'hffff_0010};
        logic [31:0] li_t [3] = '{32'h0001_2350, 32'h000f_ffff, 32'h0010_0000};
        logic [7:0]  op_t [7] = '{8'h16, 8'h07, 8'h08, 8'h09, 8'h15, 8'h1a, 8'h11};
        do_reset();
        bus(1'b1, pvc_pkg::REG_CTRL, 32'h1);
        req(32'h183, 32'h0, 32'h233b);
        expect_eq({31'h0, v86_active_q}, 32'h1, "interrupt_return entry at level 0");
        bus(1'b1, pvc_pkg::REG_CTRL, 32'h0);
        bus(1'b0, pvc_pkg::REG_STATE, 32'h0);
        expect_eq(rd & 32'h003f_ffef, 32'h003f_ffce, "v86 state");
        foreach (so_t[i]) begin
            req(32'h0, so_t[i], 32'h30c);
            expect_eq({30'h0, rd[4:3]}, (i == 2) ? 32'h3 : 32'h0, "address verdict");
            bus(1'b0, pvc_pkg::REG_LINEAR, 32'h0);
            expect_eq(rd, li_t[i], "linear address");
        end
        foreach (op_t[i]) begin
            req(32'h0, 32'h0, {16'h0, 8'h13, 4'h0, op_t[i][3:0]});
            expect_eq({30'h0, rd[4:3]}, {30'h0, op_t[i][5:4]}, "v86 op verdict");
        end
        req(32'h1cc, 32'h0, 32'h500d);
        expect_eq({31'h0, v86_active_q}, 32'h1, "exit via 16-bit gate");
        req(32'h5cc, 32'h0, 32'h500d);
        expect_eq({31'h0, v86_active_q}, 32'h0, "exit via 32-bit gate");
        bus(1'b0, pvc_pkg::REG_STATE, 32'h0);
        expect_eq({28'h0, rd[3:0]}, 32'h1, "handler at level 0");
        bus(1'b0, pvc_pkg::REG_STACK, 32'h0);
        expect_eq({rd[31], 29'h0, rd[1:0]}, 32'h8000_0000, "stacked vm image");
        req(32'h183, 32'h0, 32'h233b);
        expect_eq({31'h0, v86_active_q}, 32'h1, "return to v86 task");
        $display("test v86 done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        $display("BAD t=%0t watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, err_count, samples_checked} = '0;
        hsize = 3'h2;
        @(posedge hclk);
        t_reset();
        t_prot();
        t_v86();
        report_and_stop();
    end
endmodule
